// File: scd_pkg.sv
package scd_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_AXIS_CFG = 8'h2F;
  localparam logic [7:0] IDX_FUNC_CFG = 8'h30;
  localparam logic [7:0] IDX_UPPER_THR = 8'h38;
  localparam logic [7:0] IDX_LOWER_THR = 8'h39;
  localparam logic [7:0] IDX_OUT_DBC = 8'h3A;
  localparam logic [7:0] IDX_WIN_DBC = 8'h3B;
  localparam logic [7:0] IDX_STATUS = 8'h3C;

  // Axis enable register fields.
  localparam int unsigned AX_OUT_LATCH = 7;
  localparam int unsigned AX_WIN_LATCH = 6;
  localparam int unsigned AX_OUT_LSB = 3;
  localparam int unsigned AX_WIN_LSB = 0;

  // Function register fields.
  localparam int unsigned FN_ON = 7;
  localparam int unsigned FN_REF_MODE_LSB = 5;
  localparam int unsigned FN_OUT_DB_MODE = 4;
  localparam int unsigned FN_WIN_DB_MODE = 3;
  localparam int unsigned FN_WIN_OR = 2;
  localparam int unsigned FN_VECTOR = 1;
  localparam int unsigned FN_RELOAD = 0;

  // Reset values; the boot values apply when the boot mode pin is high.
  localparam logic [7:0] AXIS_CFG_RST = 8'h00;
  localparam logic [7:0] AXIS_CFG_BOOT = 8'h38;
  localparam logic [7:0] FUNC_CFG_RST = 8'h00;
  localparam logic [7:0] FUNC_CFG_BOOT_MOTION = 8'hD8;
  localparam logic [7:0] FUNC_CFG_BOOT_IDLE = 8'h58;
  localparam logic [11:0] THR_RST = 12'h000;
  localparam logic [7:0] DBC_RST = 8'h00;
  localparam logic [11:0] REF_RST = 12'h000;

  typedef enum logic [1:0] {
    REF_ON_OUTSIDE = 2'b00,
    REF_HOLD = 2'b01,
    REF_SLOPE = 2'b10,
    REF_ZERO = 2'b11
  } scd_ref_mode_t;

  // One output-data-rate sample of the three axes and the vector magnitude.
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [11:0] mag;
  } scd_sample_t;

endpackage

// File: scd_change_detect.sv
`timescale 1ns/1ns
`default_nettype none

module scd_debounce (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic tick,
  input wire logic cond,
  input wire logic clearMode,
  input wire logic [7:0] limit,
  // Result
  output logic active
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic active_nxt;

  always_comb begin
    if (cond) begin
      cnt_nxt = (cnt_r < limit) ? 8'(cnt_r + 8'h01) : cnt_r;
      active_nxt = active | (cnt_nxt == limit);
    end else if (clearMode) begin
      cnt_nxt = 8'h00;
      active_nxt = 1'b0;
    end else begin
      // Counting down from the limit keeps the flag for limit false periods; it drops on the next one.
      cnt_nxt = (cnt_r != 8'h00) ? 8'(cnt_r - 8'h01) : 8'h00;
      active_nxt = (cnt_r == 8'h00) ? 1'b0 : active;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      active <= 1'b0;
    end else if (clr) begin
      cnt_r <= 8'h00;
      active <= 1'b0;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
      active <= active_nxt;
    end
  end
endmodule

// Contract
// - X, Y, Z axis bits join outside evaluation.
// - X, Y, Z bits join within evaluation.
// - Enable low turns the whole function off.
// - Enabling initialises references per update mode.
// - Mode 00b: first sample, then on outside.
// - Mode 01b: first sample held until reload.
// - Mode 10b: reload after every evaluation.
// - Mode 11b: references are fixed zero.
// - Outside mode 0: count down when false.
// - Outside mode 1: clear counter when false.
// - Within mode 0: count down when false.
// - Within mode 1: clear counter when false.
// - Within combine: AND at 0, OR at 1.
// - Vector mode feeds magnitude to X only.
// - Reload strobe reloads, except in mode 11b.
// - Reload may wait up to one sample period.
// - Reload strobe clears itself when done.
// - Enable resets by boot pin and motion option.
// - Within means between thresholds, else outside.
// - Latched flags hold until status is read.
// - Activity or wake/sleep changes reset counters.
module scd_change_detect
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample stream
  input wire logic sampleTick,
  input wire scd_pkg::scd_sample_t sample,
  // Device mode inputs
  input wire logic bootModePin,
  input wire logic motionDetectOption,
  input wire logic activeMode,
  input wire logic wakeSleepChange,
  // Detection results
  output logic outsideEventActive,
  output logic withinEventActive,
  output logic [2:0] outsideAxisFlags,
  output logic [2:0] withinAxisFlags
);
  import scd_pkg::*;

  logic [7:0] axisCfg_r;
  logic [7:0] funcCfg_r;
  logic [11:0] upperThr_r;
  logic [11:0] lowerThr_r;
  logic [7:0] outDbc_r;
  logic [7:0] winDbc_r;
  logic bootDone_r;
  logic reloadPend_r;
  logic firstPend_r;
  logic activePrev_r;
  logic [11:0] refX_r;
  logic [11:0] refY_r;
  logic [11:0] refZ_r;
  logic [2:0] outsideAxis_r;
  logic [2:0] withinAxis_r;

  logic en;
  logic vecMode;
  scd_ref_mode_t refMode;
  logic wrAccess;
  logic rdAccess;
  logic hit;
  logic wrFunc;
  logic rdStatus;
  logic runTick;
  logic evalTick;
  logic refLoad;
  logic dbClr;
  logic [11:0] chanX;
  logic [12:0] dX;
  logic [12:0] dY;
  logic [12:0] dZ;
  logic [12:0] upExt;
  logic [12:0] loExt;
  logic [2:0] withinRaw;
  logic [2:0] otEn;
  logic [2:0] wtEn;
  logic [2:0] outsideEn;
  logic [2:0] withinEn;
  logic outsideCond;
  logic withinCond;
  logic [31:0] rdMux;

  assign en = funcCfg_r[FN_ON];
  assign vecMode = funcCfg_r[FN_VECTOR];
  assign refMode = scd_ref_mode_t'(funcCfg_r[FN_REF_MODE_LSB +: 2]);

  // Bus decode. The slave never inserts wait states.
  assign pready = 1'b1;
  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & penable & ~pwrite;
  assign hit = (paddr[1:0] == 2'b00) &&
    (paddr[9:2] == IDX_AXIS_CFG || paddr[9:2] == IDX_FUNC_CFG ||
     paddr[9:2] == IDX_UPPER_THR || paddr[9:2] == IDX_LOWER_THR ||
     paddr[9:2] == IDX_OUT_DBC || paddr[9:2] == IDX_WIN_DBC ||
     paddr[9:2] == IDX_STATUS);
  assign pslverr = psel & penable & ~hit;
  assign wrFunc = wrAccess && hit && paddr[9:2] == IDX_FUNC_CFG;
  assign rdStatus = rdAccess && hit && paddr[9:2] == IDX_STATUS;

  always_comb begin
    rdMux = 32'h00000000;
    unique case (paddr[9:2])
      IDX_AXIS_CFG: rdMux[7:0] = axisCfg_r;
      IDX_FUNC_CFG: rdMux[7:0] = {funcCfg_r[7:1], reloadPend_r};
      IDX_UPPER_THR: rdMux[11:0] = upperThr_r;
      IDX_LOWER_THR: rdMux[11:0] = lowerThr_r;
      IDX_OUT_DBC: rdMux[7:0] = outDbc_r;
      IDX_WIN_DBC: rdMux[7:0] = winDbc_r;
      IDX_STATUS: rdMux[7:0] = {withinAxisFlags, outsideAxisFlags,
                                withinEventActive, outsideEventActive};
      default: rdMux = 32'h00000000;
    endcase
    if (!hit) begin
      rdMux = 32'h00000000;
    end
  end

  // Read data is latched in the setup phase so it comes from a flip-flop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rdMux;
    end
  end

  // The boot strap is caught at the first edge after reset release.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bootDone_r <= 1'b0;
    end else begin
      bootDone_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      axisCfg_r <= AXIS_CFG_RST;
      funcCfg_r <= FUNC_CFG_RST;
    end else if (!bootDone_r) begin
      if (bootModePin) begin
        axisCfg_r <= AXIS_CFG_BOOT;
        funcCfg_r <= motionDetectOption ? FUNC_CFG_BOOT_MOTION : FUNC_CFG_BOOT_IDLE;
      end
    end else if (wrAccess && hit) begin
      if (paddr[9:2] == IDX_AXIS_CFG) begin
        axisCfg_r <= pwdata[7:0];
      end
      if (paddr[9:2] == IDX_FUNC_CFG) begin
        // The reload bit itself lives in its own pending flop.
        funcCfg_r <= {pwdata[7:1], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upperThr_r <= THR_RST;
      lowerThr_r <= THR_RST;
      outDbc_r <= DBC_RST;
      winDbc_r <= DBC_RST;
    end else if (wrAccess && hit) begin
      if (paddr[9:2] == IDX_UPPER_THR) begin
        upperThr_r <= pwdata[11:0];
      end
      if (paddr[9:2] == IDX_LOWER_THR) begin
        lowerThr_r <= pwdata[11:0];
      end
      if (paddr[9:2] == IDX_OUT_DBC) begin
        outDbc_r <= pwdata[7:0];
      end
      if (paddr[9:2] == IDX_WIN_DBC) begin
        winDbc_r <= pwdata[7:0];
      end
    end
  end

  // Work happens only on sample ticks while enabled and active.
  assign runTick = sampleTick & en & activeMode;
  // Absolute mode needs no captured reference, so its first tick is evaluated at once.
  assign evalTick = runTick & (~firstPend_r | (refMode == REF_ZERO));

  // The pending reload is served at the next sample tick, so software sees it set for
  // up to one sample period. A new write in the serving cycle wins over the clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reloadPend_r <= 1'b0;
    end else if (wrFunc && pwdata[FN_RELOAD]) begin
      reloadPend_r <= 1'b1;
    end else if (!en || runTick) begin
      reloadPend_r <= 1'b0;
    end
  end

  // While disabled the first-sample flag stays armed, so enabling captures in every mode except 11b.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstPend_r <= 1'b1;
    end else if (!en) begin
      firstPend_r <= 1'b1;
    end else if (runTick) begin
      firstPend_r <= 1'b0;
    end
  end

  always_comb begin
    refLoad = 1'b0;
    if (runTick) begin
      unique case (refMode)
        REF_ON_OUTSIDE: refLoad = firstPend_r | reloadPend_r | outsideEventActive;
        REF_HOLD: refLoad = firstPend_r | reloadPend_r;
        REF_SLOPE: refLoad = 1'b1;
        REF_ZERO: refLoad = 1'b0;
      endcase
    end
  end

  assign chanX = vecMode ? sample.mag : sample.x;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refX_r <= REF_RST;
      refY_r <= REF_RST;
      refZ_r <= REF_RST;
    end else if (!en || refMode == REF_ZERO) begin
      refX_r <= REF_RST;
      refY_r <= REF_RST;
      refZ_r <= REF_RST;
    end else if (refLoad) begin
      refX_r <= chanX;
      refY_r <= sample.y;
      refZ_r <= sample.z;
    end
  end

  // Magnitude is unsigned; axis data are two's complement.
  assign dX = vecMode ? 13'({1'b0, chanX} - {1'b0, refX_r})
                      : 13'({chanX[11], chanX} - {refX_r[11], refX_r});
  assign dY = 13'({sample.y[11], sample.y} - {refY_r[11], refY_r});
  assign dZ = 13'({sample.z[11], sample.z} - {refZ_r[11], refZ_r});
  assign upExt = {upperThr_r[11], upperThr_r};
  assign loExt = {lowerThr_r[11], lowerThr_r};

  always_comb begin
    withinRaw[2] = ($signed(dX) > $signed(loExt)) && ($signed(dX) < $signed(upExt));
    withinRaw[1] = ($signed(dY) > $signed(loExt)) && ($signed(dY) < $signed(upExt));
    withinRaw[0] = ($signed(dZ) > $signed(loExt)) && ($signed(dZ) < $signed(upExt));
  end

  assign otEn = axisCfg_r[AX_OUT_LSB +: 3] & (vecMode ? 3'h4 : 3'h7);
  assign wtEn = axisCfg_r[AX_WIN_LSB +: 3] & (vecMode ? 3'h4 : 3'h7);
  assign outsideEn = otEn & ~withinRaw;
  assign withinEn = wtEn & withinRaw;
  assign outsideCond = |outsideEn;
  assign withinCond = funcCfg_r[FN_WIN_OR] ? (|withinEn)
                                           : ((wtEn != 3'h0) && (withinEn == wtEn));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      activePrev_r <= 1'b0;
    end else begin
      activePrev_r <= activeMode;
    end
  end

  assign dbClr = ~en | (activeMode ^ activePrev_r) | wakeSleepChange;

  scd_debounce outsideDb (
    .clk(clk),
    .rst(rst),
    .clr(dbClr),
    .tick(evalTick),
    .cond(outsideCond),
    .clearMode(funcCfg_r[FN_OUT_DB_MODE]),
    .limit(outDbc_r),
    .active(outsideEventActive)
  );

  scd_debounce withinDb (
    .clk(clk),
    .rst(rst),
    .clr(dbClr),
    .tick(evalTick),
    .cond(withinCond),
    .clearMode(funcCfg_r[FN_WIN_DB_MODE]),
    .limit(winDbc_r),
    .active(withinEventActive)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outsideAxis_r <= 3'h0;
      withinAxis_r <= 3'h0;
    end else if (!en) begin
      outsideAxis_r <= 3'h0;
      withinAxis_r <= 3'h0;
    end else if (evalTick) begin
      outsideAxis_r <= outsideEn;
      withinAxis_r <= withinEn;
    end
  end

  // Latched flags survive until a status read; a new event in that cycle still sets them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outsideAxisFlags <= 3'h0;
      withinAxisFlags <= 3'h0;
    end else if (!en) begin
      outsideAxisFlags <= 3'h0;
      withinAxisFlags <= 3'h0;
    end else begin
      if (axisCfg_r[AX_OUT_LATCH]) begin
        outsideAxisFlags <= (outsideAxisFlags & {3{~rdStatus}}) |
                            (outsideAxis_r & {3{outsideEventActive}});
      end else begin
        outsideAxisFlags <= outsideAxis_r & {3{outsideEventActive}};
      end
      if (axisCfg_r[AX_WIN_LATCH]) begin
        withinAxisFlags <= (withinAxisFlags & {3{~rdStatus}}) |
                           (withinAxis_r & {3{withinEventActive}});
      end else begin
        withinAxisFlags <= withinAxis_r & {3{withinEventActive}};
      end
    end
  end

  property p_zero_refs;
    @(posedge clk) disable iff (rst)
    (en && refMode == REF_ZERO) ##1 (en && refMode == REF_ZERO)
      |-> (refX_r == 12'h000 && refY_r == 12'h000 && refZ_r == 12'h000);
  endproperty
  a_zero_refs: assert property (p_zero_refs) else $error("refs not zero in absolute mode");

  property p_off_quiet;
    @(posedge clk) disable iff (rst)
    !en |=> (!outsideEventActive && !withinEventActive && outsideAxisFlags == 3'h0);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity while disabled");

  property p_reload_done;
    @(posedge clk) disable iff (rst)
    (reloadPend_r && runTick && !wrFunc) |=> !reloadPend_r;
  endproperty
  a_reload_done: assert property (p_reload_done) else $error("reload bit did not clear");

  property p_slope_load;
    @(posedge clk) disable iff (rst)
    (runTick && refMode == REF_SLOPE && !vecMode) ##1 en |-> refX_r == $past(sample.x);
  endproperty
  a_slope_load: assert property (p_slope_load) else $error("slope ref not loaded");

  property p_hold_refs;
    @(posedge clk) disable iff (rst)
    (en && refMode == REF_HOLD && !refLoad) ##1 (en && refMode == REF_HOLD)
      |-> $stable(refX_r) && $stable(refY_r) && $stable(refZ_r);
  endproperty
  a_hold_refs: assert property (p_hold_refs) else $error("held refs changed");

  property p_and_combine;
    @(posedge clk) disable iff (rst)
    (!funcCfg_r[FN_WIN_OR] && (wtEn & ~withinRaw) != 3'h0) |-> !withinCond;
  endproperty
  a_and_combine: assert property (p_and_combine) else $error("AND combine wrong");

  property p_outside_enabled;
    @(posedge clk) disable iff (rst)
    (otEn == 3'h0) |-> !outsideCond;
  endproperty
  a_outside_enabled: assert property (p_outside_enabled) else $error("disabled axis used");

  property p_boot_off;
    @(posedge clk) disable iff (rst)
    (!bootDone_r && !bootModePin) ##1 !wrFunc[*1] |-> !funcCfg_r[FN_ON];
  endproperty
  a_boot_off: assert property (p_boot_off) else $error("enable set after low boot pin");

  property p_out_clear_mode;
    @(posedge clk) disable iff (rst)
    (evalTick && funcCfg_r[FN_OUT_DB_MODE] && !outsideCond) |=> !outsideEventActive;
  endproperty
  a_out_clear_mode: assert property (p_out_clear_mode) else $error("outside flag kept");

  c_outside_event: cover property (@(posedge clk) disable iff (rst) $rose(outsideEventActive));
  c_within_event: cover property (@(posedge clk) disable iff (rst) $rose(withinEventActive));
  c_reload: cover property (@(posedge clk) disable iff (rst) reloadPend_r && runTick);
  c_latched_read: cover property (@(posedge clk) disable iff (rst)
    rdStatus && outsideAxisFlags != 3'h0);

endmodule

`default_nettype wire

// File: scd_tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  import scd_pkg::*;

  typedef struct {
    string nm;
    logic [31:0] val;
    logic [31:0] mask;
    logic err;
  } scd_exp_t;

  logic clk, rst, psel, penable, pwrite, pready, pslverr, sampleTick;
  logic bootModePin, motionDetectOption, activeMode, wakeSleepChange;
  logic outsideEventActive, withinEventActive;
  logic [2:0] outsideAxisFlags, withinAxisFlags;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, d;
  scd_sample_t sample;
  scd_exp_t expQ[$];
  logic [5:0] ax;
  logic [2:0] r;
  logic [11:0] o, tv, fv;
  logic eo, ew;
  int num_errors = 0;
  int num_checks = 0;

  scd_change_detect u_scd_change_detect (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleTick(sampleTick), .sample(sample),
    .bootModePin(bootModePin), .motionDetectOption(motionDetectOption),
    .activeMode(activeMode), .wakeSleepChange(wakeSleepChange),
    .outsideEventActive(outsideEventActive), .withinEventActive(withinEventActive),
    .outsideAxisFlags(outsideAxisFlags), .withinAxisFlags(withinAxisFlags)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Read data is judged by this watcher, not by the driver, at the sampling edge.
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (expQ.size() == 0) begin
        check("unexpected read", 32'h1, 32'h0);
      end else begin
        check(expQ[0].nm, expQ[0].val, prdata & expQ[0].mask);
        check({expQ[0].nm, " error flag"}, {31'h0, expQ[0].err}, {31'h0, pslverr});
        void'(expQ.pop_front());
      end
    end
  end

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("bus answer", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(idx, 1'b1, wd);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] v, input logic [31:0] m,
                    input string nm, input logic e = 1'b0);
    expQ.push_back('{nm, v, m, e});
    apb(idx, 1'b0, 32'h0);
  endtask

  // Between ticks the sample lines carry noise, so stale data cannot pass for valid data.
  task automatic tick(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z,
                      input logic [11:0] m);
    @(posedge clk);
    sampleTick <= 1'b1;
    sample <= '{x: x, y: y, z: z, mag: m};
    @(posedge clk);
    sampleTick <= 1'b0;
    sample <= scd_sample_t'(48'({$urandom(), $urandom()}));
    repeat (2) @(posedge clk);
  endtask

  task automatic tst(input logic [11:0] x, input logic e);
    tick(x, 12'h0, 12'h0, 12'h0);
    rd(IDX_STATUS, {31'h0, e}, 32'h1, "outside status");
  endtask

  task automatic db(input logic c, input logic e, input int w);
    tick(c ? tv : fv, 12'h0, 12'h0, 12'h0);
    rd(IDX_STATUS, 32'(e) << w, 32'h1 << w, "debounce status");
  endtask

  task automatic doReset(input logic boot, input logic mot);
    @(posedge clk);
    rst <= 1'b1;
    bootModePin <= boot;
    motionDetectOption <= mot;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic toggleActive();
    @(posedge clk);
    activeMode <= 1'b0;
    repeat (2) @(posedge clk);
    activeMode <= 1'b1;
  endtask

  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h0;
    pwdata = 32'h0;
    sampleTick = 1'b0;
    sample = '0;
    bootModePin = 1'b0;
    motionDetectOption = 1'b0;
    activeMode = 1'b1;
    wakeSleepChange = 1'b0;
    void'($urandom(32'h451A45B2));
    for (int b = 0; b < 3; b++) begin
      doReset(b > 0, b == 2);
      rd(IDX_FUNC_CFG, {24'h0, b == 2, 7'h0}, 32'h80, "enable after reset");
    end
    doReset(1'b0, 1'b0);
    rd(IDX_AXIS_CFG, 32'h0, 32'hFFFFFFFF, "axis cfg reset");
    rd(IDX_FUNC_CFG, 32'h0, 32'hFFFFFFFF, "func cfg reset");
    rd(8'h10, 32'h0, 32'hFFFFFFFF, "unmapped", 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      wr(IDX_AXIS_CFG, d);
      rd(IDX_AXIS_CFG, d & 32'hFF, 32'hFFFFFFFF, "axis cfg");
      wr(IDX_FUNC_CFG, d & 32'h7E);
      rd(IDX_FUNC_CFG, d & 32'h7E, 32'hFFFFFFFF, "func cfg");
      wr(IDX_UPPER_THR, d);
      rd(IDX_UPPER_THR, d & 32'hFFF, 32'hFFF, "upper threshold");
    end
    $display("test registers done");
    wr(IDX_FUNC_CFG, 32'h0);
    wr(IDX_UPPER_THR, 32'h100);
    wr(IDX_LOWER_THR, 32'h010);
    for (int i = 0; i < 16; i++) begin
      ax = 6'($urandom());
      r = 3'($urandom());
      o = i[1] ? 12'h100 : 12'h010;
      wr(IDX_FUNC_CFG, {24'h0, 5'b11100, i[0], 2'b00});
      wr(IDX_AXIS_CFG, {26'h0, ax});
      tick(r[2] ? 12'h080 : o, r[1] ? 12'h080 : o, r[0] ? 12'h080 : o, 12'h0);
      eo = |(~r & ax[5:3]);
      ew = i[0] ? |(r & ax[2:0]) : (ax[2:0] != 3'h0) && ((r | ~ax[2:0]) == 3'h7);
      rd(IDX_STATUS, {30'h0, ew, eo}, 32'h3, "window status");
    end
    $display("test window done");
    wr(IDX_AXIS_CFG, 32'h3F);
    wr(IDX_FUNC_CFG, 32'hE2);
    tick(12'h200, 12'h200, 12'h200, 12'h080);
    rd(IDX_STATUS, 32'h2, 32'h3, "vector status");
    tick(12'h080, 12'h080, 12'h080, 12'h200);
    rd(IDX_STATUS, 32'h1, 32'h3, "vector status");
    $display("test vector done");
    // A negative lower bound lets a zero delta sit inside the window.
    wr(IDX_LOWER_THR, 32'hFF0);
    wr(IDX_AXIS_CFG, 32'h20);
    wr(IDX_FUNC_CFG, 32'h0);
    wr(IDX_FUNC_CFG, 32'hA0);
    tick(12'h300, 12'h0, 12'h0, 12'h0);
    tst(12'h3F0, 1'b0);
    tst(12'h300, 1'b0);
    wr(IDX_FUNC_CFG, 32'hA1);
    rd(IDX_FUNC_CFG, 32'h1, 32'h1, "reload pending");
    tick(12'h200, 12'h0, 12'h0, 12'h0);
    rd(IDX_FUNC_CFG, 32'hA0, 32'hFF, "reload done");
    tst(12'h280, 1'b0);
    wr(IDX_FUNC_CFG, 32'h0);
    wr(IDX_FUNC_CFG, 32'hC0);
    tick(12'h100, 12'h0, 12'h0, 12'h0);
    tst(12'h180, 1'b0);
    tst(12'h200, 1'b0);
    tst(12'h300, 1'b1);
    tst(12'h380, 1'b0);
    wr(IDX_FUNC_CFG, 32'h0);
    wr(IDX_FUNC_CFG, 32'h80);
    tick(12'h100, 12'h0, 12'h0, 12'h0);
    tst(12'h400, 1'b1);
    tick(12'h400, 12'h0, 12'h0, 12'h0);
    tst(12'h480, 1'b0);
    wr(IDX_FUNC_CFG, 32'h0);
    wr(IDX_FUNC_CFG, 32'hE1);
    tst(12'h0F0, 1'b0);
    tst(12'h000, 1'b0);
    $display("test reference modes done");
    wr(IDX_AXIS_CFG, 32'hA0);
    tick(12'h400, 12'h0, 12'h0, 12'h0);
    tick(12'h000, 12'h0, 12'h0, 12'h0);
    rd(IDX_STATUS, 32'h10, 32'h1F, "latched flags");
    rd(IDX_STATUS, 32'h00, 32'h1F, "flags after read");
    $display("test latch done");
    for (int w = 0; w < 2; w++) begin
      tv = w ? 12'h080 : 12'h200;
      fv = w ? 12'h200 : 12'h080;
      wr(w ? IDX_WIN_DBC : IDX_OUT_DBC, 32'h2);
      wr(IDX_AXIS_CFG, w ? 32'h04 : 32'h20);
      wr(IDX_FUNC_CFG, 32'hE0);
      toggleActive();
      db(1'b1, 1'b0, w);
      db(1'b1, 1'b1, w);
      db(1'b0, 1'b1, w);
      db(1'b0, 1'b1, w);
      db(1'b0, 1'b0, w);
      wr(IDX_FUNC_CFG, w ? 32'hE8 : 32'hF0);
      db(1'b1, 1'b0, w);
      db(1'b1, 1'b1, w);
      db(1'b0, 1'b0, w);
      db(1'b1, 1'b0, w);
      @(posedge clk);
      wakeSleepChange <= 1'b1;
      @(posedge clk);
      wakeSleepChange <= 1'b0;
      db(1'b1, 1'b0, w);
      db(1'b1, 1'b1, w);
      db(1'b0, 1'b0, w);
      db(1'b1, 1'b0, w);
      toggleActive();
      db(1'b1, 1'b0, w);
    end
    $display("test debounce done");
    repeat (4) @(posedge clk);
    finish_test();
  end

endmodule

`default_nettype wire
